// ### design/i2c_ctl_map.svh
`ifndef I2C_CTL_MAP_SVH
`define I2C_CTL_MAP_SVH

// Fixed upper five bits of the own slave address (00110)
`define OWN_ADDR_HI5      5'h06
`define GEN_CALL_ADDR     8'h00
`define BYTE_BITS         4'h8
`define LAST_BIT          4'h7

// Register map locations
`define REG_PAGE_SEL      7'h00
`define REG_DEBUG         7'h6B
`define DEBUG_PAGE        8'h00
`define DBG_STAT_BIT      0
`define DBG_DIS_BIT       2
`define PAGE_RESET        8'h00

// Timing
`define CLK_PERIOD_NS     100
`define BUSERR_TIMEOUT_US 1000
`define BUSERR_CYCLES     (`BUSERR_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)

`endif

// ### design/i2c_ctl_pkg.sv
`default_nettype none
package i2c_ctl_pkg;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_ADDR     = 3'h1,
		ST_ADDR_ACK = 3'h2,
		ST_RX       = 3'h3,
		ST_RX_ACK   = 3'h4,
		ST_TX       = 3'h5,
		ST_TX_ACK   = 3'h6,
		ST_WAIT     = 3'h7
	} ctl_st_t;

	// Synchronised line levels and the events found on them
	typedef struct packed {
		logic scl;
		logic sda;
		logic sel_n;
		logic strap_hi;
		logic strap_lo;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} line_ev_t;

	typedef struct packed {
		ctl_st_t     st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic        rw;
		logic        gc;
		logic        first;
		logic        mack;
		logic [6:0]  ptr;
		logic [7:0]  page;
		logic        det_dis;
		logic        err_stat;
		logic        err_pulse;
		logic        sda_lvl;
		logic        sda_oe;
		logic        we;
		logic [7:0]  waddr;
		logic [7:0]  wdata;
		logic [15:0] idle_cnt;
	} ctl_state_t;

endpackage
`default_nettype wire

// ### design/i2c_ctl_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ctl_map.svh"
module i2c_ctl_slave #(
	parameter int BUSERR_CYCLES = `BUSERR_CYCLES
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       proto_sel_n,
	input  wire logic       addr_strap_high_pin,
	input  wire logic       addr_strap_low_pin,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	output var  logic [7:0] active_page,
	output var  logic       bus_err_status,
	output var  logic       bus_err_det_off
);
	import i2c_ctl_pkg::*;

	localparam logic [15:0] ERR_LIM = 16'(BUSERR_CYCLES);

	line_ev_t   ev;
	ctl_state_t s_r;
	ctl_state_t s_nxt;
	logic [7:0] rdata;
	logic [6:0] own_addr;
	logic       err_fire;
	logic       quiet;

	function automatic logic [7:0] mem_idx(input logic [7:0] page,
		input logic [6:0] reg_no);
		// Only two pages exist, so the page's low bit picks the half
		mem_idx = {page[0], reg_no};
	endfunction

	function automatic logic [7:0] read_byte(input logic [7:0] mem,
		input ctl_state_t st);
		read_byte = mem;
		if (st.ptr == `REG_PAGE_SEL)
			read_byte = st.page;
		else if (st.page == `DEBUG_PAGE && st.ptr == `REG_DEBUG)
		begin
			read_byte[`DBG_STAT_BIT] = st.err_stat;
			read_byte[`DBG_DIS_BIT]  = st.det_dis;
		end
	endfunction

	i2c_line_sync u_sync (
		.clk_sys             (clk_sys),
		.rst                 (rst),
		.scl_in              (scl_in),
		.sda_in              (sda_in),
		.proto_sel_n         (proto_sel_n),
		.addr_strap_high_pin (addr_strap_high_pin),
		.addr_strap_low_pin  (addr_strap_low_pin),
		.ev                  (ev)
	);

	reg_page_mem u_mem (
		.clk_sys (clk_sys),
		.we      (s_r.we),
		.waddr   (s_r.waddr),
		.wdata   (s_r.wdata),
		.raddr   (mem_idx(s_r.page, s_r.ptr)),
		.rdata   (rdata)
	);

	assign own_addr = {`OWN_ADDR_HI5, ev.strap_hi, ev.strap_lo};
	assign err_fire = !s_r.det_dis && s_r.idle_cnt == ERR_LIM;
	assign quiet    = !ev.sel_n && !ev.start && !ev.stop && !err_fire;

	always_comb
	begin
		s_nxt           = s_r;
		s_nxt.we        = 1'b0;
		s_nxt.err_pulse = 1'b0;
		s_nxt.sda_lvl   = 1'b0;
		// A transfer that sees no clock edge for the timeout is hung
		if (ev.scl_rise || ev.scl_fall || s_r.st == ST_IDLE
			|| s_r.st == ST_WAIT)
			s_nxt.idle_cnt = 16'h0000;
		else if (s_r.idle_cnt != ERR_LIM)
			s_nxt.idle_cnt = s_r.idle_cnt + 16'h0001;
		if (ev.sel_n)
		begin
			s_nxt.st     = ST_IDLE;
			s_nxt.sda_oe = 1'b0;
		end
		else if (ev.stop)
		begin
			s_nxt.st     = ST_IDLE;
			s_nxt.sda_oe = 1'b0;
		end
		else if (ev.start)
		begin
			s_nxt.st     = ST_ADDR;
			s_nxt.cnt    = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end
		else if (err_fire)
		begin
			s_nxt.st        = ST_IDLE;
			s_nxt.sda_oe    = 1'b0;
			s_nxt.err_stat  = 1'b1;
			s_nxt.err_pulse = 1'b1;
		end
		else
		begin
			unique case (s_r.st)
				ST_IDLE, ST_WAIT:
					s_nxt.cnt = 4'h0;
				ST_ADDR:
					if (ev.scl_rise)
					begin
						s_nxt.sh  = {s_r.sh[6:0], ev.sda};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end
					else if (ev.scl_fall && s_r.cnt == `BYTE_BITS)
					begin
						if (s_r.sh[7:1] == own_addr)
						begin
							s_nxt.st     = ST_ADDR_ACK;
							s_nxt.sda_oe = 1'b1;
							s_nxt.rw     = s_r.sh[0];
							s_nxt.gc     = 1'b0;
						end
						else if (s_r.sh == `GEN_CALL_ADDR)
						begin
							s_nxt.st     = ST_ADDR_ACK;
							s_nxt.sda_oe = 1'b1;
							s_nxt.gc     = 1'b1;
						end
						else
							s_nxt.st = ST_WAIT;
					end
				ST_ADDR_ACK:
					if (ev.scl_fall)
					begin
						s_nxt.cnt = 4'h0;
						if (s_r.gc)
						begin
							s_nxt.st     = ST_WAIT;
							s_nxt.sda_oe = 1'b0;
						end
						else if (s_r.rw)
						begin
							s_nxt.st     = ST_TX;
							s_nxt.tx     = read_byte(rdata, s_r);
							s_nxt.sda_oe = ~s_nxt.tx[7];
							if (s_r.page == `DEBUG_PAGE && s_r.ptr == `REG_DEBUG)
								s_nxt.err_stat = 1'b0;
						end
						else
						begin
							s_nxt.st     = ST_RX;
							s_nxt.sda_oe = 1'b0;
							s_nxt.first  = 1'b1;
						end
					end
				ST_RX:
					if (ev.scl_rise)
					begin
						s_nxt.sh  = {s_r.sh[6:0], ev.sda};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end
					else if (ev.scl_fall && s_r.cnt == `BYTE_BITS)
					begin
						s_nxt.st     = ST_RX_ACK;
						s_nxt.sda_oe = 1'b1;
						s_nxt.first  = 1'b0;
						if (s_r.first)
							s_nxt.ptr = s_r.sh[6:0];
						else
						begin
							s_nxt.we    = 1'b1;
							s_nxt.waddr = mem_idx(s_r.page, s_r.ptr);
							s_nxt.wdata = s_r.sh;
							s_nxt.ptr   = s_r.ptr + 7'h01;
							if (s_r.ptr == `REG_PAGE_SEL)
								s_nxt.page = s_r.sh;
							if (s_r.page == `DEBUG_PAGE && s_r.ptr == `REG_DEBUG)
								s_nxt.det_dis = s_r.sh[`DBG_DIS_BIT];
						end
					end
				ST_RX_ACK:
					if (ev.scl_fall)
					begin
						s_nxt.st     = ST_RX;
						s_nxt.sda_oe = 1'b0;
						s_nxt.cnt    = 4'h0;
					end
				ST_TX:
					if (ev.scl_fall)
					begin
						if (s_r.cnt == `LAST_BIT)
						begin
							s_nxt.st     = ST_TX_ACK;
							s_nxt.sda_oe = 1'b0;
							s_nxt.cnt    = 4'h0;
							s_nxt.ptr    = s_r.ptr + 7'h01;
						end
						else
						begin
							s_nxt.cnt    = s_r.cnt + 4'h1;
							s_nxt.tx     = {s_r.tx[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.tx[6];
						end
					end
				ST_TX_ACK:
					if (ev.scl_rise)
						s_nxt.mack = ~ev.sda;
					else if (ev.scl_fall)
					begin
						if (s_r.mack)
						begin
							s_nxt.st     = ST_TX;
							s_nxt.cnt    = 4'h0;
							s_nxt.tx     = read_byte(rdata, s_r);
							s_nxt.sda_oe = ~s_nxt.tx[7];
							if (s_r.page == `DEBUG_PAGE && s_r.ptr == `REG_DEBUG)
								s_nxt.err_stat = 1'b0;
						end
						else
						begin
							s_nxt.st     = ST_WAIT;
							s_nxt.sda_oe = 1'b0;
						end
					end
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign sda_out         = s_r.sda_lvl;
	assign sda_oe          = s_r.sda_oe;
	assign active_page     = s_r.page;
	assign bus_err_status  = s_r.err_stat;
	assign bus_err_det_off = s_r.det_dis;

	a_spi_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		ev.sel_n |=> !s_r.sda_oe && s_r.st == ST_IDLE)
		else $error("port active while protocol select is high");

	a_stop_idle: assert property (@(posedge clk_sys) disable iff (rst)
		(!ev.sel_n && ev.stop) |=> s_r.st == ST_IDLE && !s_r.sda_oe)
		else $error("stop did not return to idle");

	a_start_addr: assert property (@(posedge clk_sys) disable iff (rst)
		(!ev.sel_n && !ev.stop && ev.start)
		|=> s_r.st == ST_ADDR && s_r.cnt == 4'h0)
		else $error("start did not restart address decoding");

	a_addr_match: assert property (@(posedge clk_sys) disable iff (rst)
		(quiet && s_r.st == ST_ADDR && ev.scl_fall && s_r.cnt == `BYTE_BITS
		&& s_r.sh[7:1] == own_addr) |=> s_r.st == ST_ADDR_ACK && s_r.sda_oe)
		else $error("own address not acknowledged");

	a_gcall_ack: assert property (@(posedge clk_sys) disable iff (rst)
		(quiet && s_r.st == ST_ADDR && ev.scl_fall && s_r.cnt == `BYTE_BITS
		&& s_r.sh == `GEN_CALL_ADDR) |=> s_r.sda_oe ##1 s_r.gc)
		else $error("general call not acknowledged");

	a_foreign_addr: assert property (@(posedge clk_sys) disable iff (rst)
		(quiet && s_r.st == ST_ADDR && ev.scl_fall && s_r.cnt == `BYTE_BITS
		&& s_r.sh[7:1] != own_addr && s_r.sh != `GEN_CALL_ADDR)
		|=> s_r.st == ST_WAIT && !s_r.sda_oe)
		else $error("foreign address not ignored");

	a_drive_clock_low: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(s_r.sda_oe) |-> !$past(ev.scl) && !s_r.sda_lvl)
		else $error("data pulled low while clock high");

	a_write_incr: assert property (@(posedge clk_sys) disable iff (rst)
		s_r.we |-> s_r.ptr == 7'(s_r.waddr[6:0] + 7'h01)
		&& s_r.waddr[7] == $past(s_r.page[0]))
		else $error("write pointer did not advance");

	a_read_next: assert property (@(posedge clk_sys) disable iff (rst)
		(quiet && s_r.st == ST_TX_ACK && ev.scl_fall && s_r.mack)
		|=> s_r.st == ST_TX && s_r.cnt == 4'h0 && s_r.sda_oe == ~s_r.tx[7])
		else $error("next read byte not sent after acknowledge");

	a_nack_release: assert property (@(posedge clk_sys) disable iff (rst)
		(quiet && s_r.st == ST_TX_ACK && ev.scl_fall && !s_r.mack)
		|=> s_r.st == ST_WAIT && !s_r.sda_oe)
		else $error("data not released after not-acknowledge");

	a_err_release: assert property (@(posedge clk_sys) disable iff (rst)
		(err_fire && !ev.sel_n && !ev.start && !ev.stop)
		|=> s_r.st == ST_IDLE && !s_r.sda_oe && s_r.err_stat && s_r.err_pulse)
		else $error("hung bus not released");

	a_err_disabled: assert property (@(posedge clk_sys) disable iff (rst)
		s_r.det_dis && $past(s_r.det_dis) |-> !s_r.err_pulse)
		else $error("disabled detector still fired");

	c_reg_write: cover property (@(posedge clk_sys) disable iff (rst)
		s_r.we);
	c_read_burst: cover property (@(posedge clk_sys) disable iff (rst)
		s_r.st == ST_TX_ACK && ev.scl_fall && s_r.mack);
	c_restart: cover property (@(posedge clk_sys) disable iff (rst)
		ev.start && s_r.st != ST_IDLE && !ev.sel_n);
	c_bus_error: cover property (@(posedge clk_sys) disable iff (rst)
		s_r.err_pulse);
endmodule
`default_nettype wire

// ### design/i2c_line_sync.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_line_sync (
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	input  wire logic                 proto_sel_n,
	input  wire logic                 addr_strap_high_pin,
	input  wire logic                 addr_strap_low_pin,
	output var  i2c_ctl_pkg::line_ev_t ev
);
	import i2c_ctl_pkg::*;

	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [1:0] s3;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	// Only the second stage and the delayed copy feed any logic
	always_comb
	begin
		s_nxt    = s_r;
		s_nxt.s1 = {scl_in, sda_in, proto_sel_n, addr_strap_high_pin,
			addr_strap_low_pin};
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2[4:3];
	end

	always_ff @(posedge clk_sys)
	begin
		// Idle bus levels, so no false clock edge or START follows reset
		if (rst)
			s_r <= '{s1: 5'h18, s2: 5'h18, s3: 2'h3};
		else
			s_r <= s_nxt;
	end

	always_comb
	begin
		ev.scl      = s_r.s2[4];
		ev.sda      = s_r.s2[3];
		ev.sel_n    = s_r.s2[2];
		ev.strap_hi = s_r.s2[1];
		ev.strap_lo = s_r.s2[0];
		ev.scl_rise = s_r.s2[4] & ~s_r.s3[1];
		ev.scl_fall = ~s_r.s2[4] & s_r.s3[1];
		ev.start    = s_r.s2[4] & s_r.s3[1] & s_r.s3[0] & ~s_r.s2[3];
		ev.stop     = s_r.s2[4] & s_r.s3[1] & ~s_r.s3[0] & s_r.s2[3];
	end
endmodule
`default_nettype wire

// ### design/reg_page_mem.sv
`timescale 1ns/10ps
`default_nettype none
module reg_page_mem (
	input  wire logic       clk_sys,
	input  wire logic       we,
	input  wire logic [7:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] raddr,
	output var  logic [7:0] rdata
);
	// Two pages of 128 bytes; contents are undefined until written
	logic [7:0] mem_r [0:255];

	always_ff @(posedge clk_sys)
	begin
		if (we)
			mem_r[waddr] <= wdata;
		rdata <= mem_r[raddr];
	end
endmodule
`default_nettype wire

// ### sim/i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
	input  wire logic       clk_sys,
	input  wire logic       sda_in,
	output var  logic       scl,
	output var  logic       sda_oe,
	output var  logic       res_valid,
	output var  logic [7:0] res_data
);
	initial
	begin
		scl = 1'b1;
		sda_oe = 1'b0;
		res_valid = 1'b0;
		res_data = 8'h00;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// Data only moves a cycle after SCL fell, never while it is high
	task automatic bit_x(input logic b, output logic r);
		tick(1);
		sda_oe = ~b;
		tick(3);
		scl = 1'b1;
		tick(2);
		r = sda_in;
		tick(2);
		scl = 1'b0;
	endtask

	// Long low phase gives the slave time to let go of its acknowledge
	task automatic start_c();
		tick(1);
		sda_oe = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(4);
		sda_oe = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask

	task automatic stop_c();
		tick(1);
		sda_oe = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(4);
		sda_oe = 1'b0;
		tick(4);
	endtask

	// Reports read data, or the acknowledge bit of a written byte
	task automatic xfer(input logic rd, input logic [7:0] d,
		input logic mack);
		logic [7:0] r;
		logic       a;
		for (int i = 7; i >= 0; i--)
			bit_x(rd | d[i], r[i]);
		bit_x(rd ? mack : 1'b1, a);
		res_data = rd ? r : {7'h00, a};
		res_valid = 1'b1;
		tick(1);
		res_valid = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### sim/i2c_register_control_slave_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_ctl_map.svh"
`define CHK(nm, ex, gt) \
	begin \
		samples_checked++; \
		if ((gt) !== (ex)) \
		begin \
			bad_count++; \
			$display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module i2c_register_control_slave_tb_top;
	localparam int ERR_CYC = 200;
	logic       clk_sys;
	logic       rst;
	logic       proto_sel_n;
	logic       addr_strap_high_pin;
	logic       addr_strap_low_pin;
	logic       scl;
	logic       host_oe;
	logic       sda_wire;
	logic       sda_out;
	logic       sda_oe;
	logic [7:0] active_page;
	logic       bus_err_status;
	logic       bus_err_det_off;
	logic       res_valid;
	logic [7:0] res_data;
	logic [7:0] expq[$];
	logic [7:0] d[3];
	logic [7:0] e;
	logic [31:0] rng;
	int         bad_count;
	int         samples_checked;
	int         cyc;

	// Pull-up wins whenever nobody pulls low
	assign sda_wire = ~(sda_oe | host_oe);

	i2c_ctl_slave #(
		.BUSERR_CYCLES(ERR_CYC)
	) dut_u (
		.clk_sys            (clk_sys),
		.rst                (rst),
		.proto_sel_n        (proto_sel_n),
		.addr_strap_high_pin(addr_strap_high_pin),
		.addr_strap_low_pin (addr_strap_low_pin),
		.scl_in             (scl),
		.sda_in             (sda_wire),
		.sda_out            (sda_out),
		.sda_oe             (sda_oe),
		.active_page        (active_page),
		.bus_err_status     (bus_err_status),
		.bus_err_det_off    (bus_err_det_off)
	);

	i2c_host_model host_u (
		.clk_sys  (clk_sys),
		.sda_in   (sda_wire),
		.scl      (scl),
		.sda_oe   (host_oe),
		.res_valid(res_valid),
		.res_data (res_data)
	);

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	function automatic logic [7:0] own(input logic rd);
		return {`OWN_ADDR_HI5, addr_strap_high_pin, addr_strap_low_pin, rd};
	endfunction

	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic tx(input logic [7:0] b, input logic ack);
		expq.push_back({7'h00, ack});
		host_u.xfer(1'b0, b, 1'b1);
	endtask

	task automatic rx(input logic [7:0] x, input logic mack);
		expq.push_back(x);
		host_u.xfer(1'b1, 8'hFF, mack);
	endtask

	task automatic wr1(input logic [6:0] r, input logic [7:0] x);
		host_u.start_c();
		tx(own(0), 0);
		tx({1'b0, r}, 0);
		tx(x, 0);
		host_u.stop_c();
	endtask

	task automatic rd1(input logic [6:0] r, input logic [7:0] x);
		host_u.start_c();
		tx(own(0), 0);
		tx({1'b0, r}, 0);
		host_u.start_c();
		tx(own(1), 0);
		rx(x, 1);
		host_u.stop_c();
	endtask

	// Hang the bus with SCL low right after an acknowledged address
	task automatic stall();
		host_u.start_c();
		tx(own(0), 0);
		repeat (ERR_CYC + 50) @(negedge clk_sys);
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		if (res_valid)
		begin
			e = (expq.size() > 0) ? expq.pop_front() : ~res_data;
			`CHK("bus_byte", e, res_data)
		end
		if (sda_oe === 1'b1)
			`CHK("sda_drive", 1'b0, sda_out)
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			results();
		end
	end

	initial
	begin
		rst = 1'b1;
		proto_sel_n = 1'b0;
		addr_strap_high_pin = 1'b0;
		addr_strap_low_pin = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		cyc = 0;
		rng = 32'hfaa2;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		`CHK("page_rst", 8'h00, active_page)
		`CHK("err_rst", 1'b0, bus_err_status)
		`CHK("dis_rst", 1'b0, bus_err_det_off)
		for (int i = 0; i < 4; i++)
		begin
			{addr_strap_high_pin, addr_strap_low_pin} = i[1:0];
			repeat (4) @(negedge clk_sys);
			host_u.start_c();
			tx(own(0), 0);
			host_u.stop_c();
			host_u.start_c();
			tx(own(0) ^ (8'h02 << i[0]), 1);
			host_u.stop_c();
		end
		for (int k = 0; k < 3; k++)
		begin
			rng = xs(rng);
			d[k] = rng[7:0];
		end
		// Burst stays well inside the page
		host_u.start_c();
		tx(own(0), 0);
		tx(8'h05, 0);
		for (int k = 0; k < 3; k++)
			tx(d[k], 0);
		host_u.stop_c();
		host_u.start_c();
		tx(own(0), 0);
		tx(8'h05, 0);
		host_u.start_c();
		tx(own(1), 0);
		rx(d[0], 0);
		rx(d[1], 0);
		rx(d[2], 1);
		repeat (6) @(negedge clk_sys);
		`CHK("nack_release", 1'b0, sda_oe)
		host_u.stop_c();
		wr1(`REG_PAGE_SEL, 8'h01);
		`CHK("page_sel", 8'h01, active_page)
		wr1(7'h05, ~d[0]);
		rd1(`REG_PAGE_SEL, 8'h01);
		wr1(`REG_PAGE_SEL, 8'h00);
		rd1(7'h05, d[0]);
		host_u.start_c();
		tx(`GEN_CALL_ADDR, 0);
		tx(8'h5A, 1);
		host_u.stop_c();
		wr1(`REG_DEBUG, 8'h04);
		`CHK("det_off", 1'b1, bus_err_det_off)
		stall();
		`CHK("no_err", 1'b0, bus_err_status)
		host_u.stop_c();
		wr1(`REG_DEBUG, 8'h00);
		`CHK("det_on", 1'b0, bus_err_det_off)
		stall();
		`CHK("err_set", 1'b1, bus_err_status)
		`CHK("err_free", 1'b0, sda_oe)
		host_u.stop_c();
		rd1(`REG_DEBUG, 8'h01);
		`CHK("err_clr", 1'b0, bus_err_status)
		proto_sel_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		host_u.start_c();
		tx(own(0), 1);
		host_u.stop_c();
		proto_sel_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		rd1(7'h05, d[0]);
		results();
	end
endmodule
`default_nettype wire
